// ==== rtl/csm_pkg.sv ====
// Purpose: Constants and types for the configuration space mirror block.
// Assumes: One user clock, synchronous active-low reset.
// Notes:   Offsets are field positions inside the 16-bit mirrors.
package csm_pkg;

  typedef enum logic [2:0] {
    CSM_SEL_COMMAND,
    CSM_SEL_DEV_STATUS,
    CSM_SEL_DEV_CTL,
    CSM_SEL_LINK_STATUS,
    CSM_SEL_LINK_CTL,
    CSM_SEL_DEV_CTL2
  } csm_sel_e;

  localparam logic [15:0] CSM_CMD_WMASK     = 16'h0507;
  localparam logic [15:0] CSM_DCTL_WMASK    = 16'h7fff;
  localparam logic [15:0] CSM_LCTL_WMASK    = 16'h0ffb;
  localparam logic [15:0] CSM_LCTL_EP_WMASK = 16'h0fdb;
  localparam logic [15:0] CSM_DCTL2_WMASK   = 16'h001f;
  localparam logic [15:0] CSM_LSTAT_W1C     = 16'hc000;

  localparam int CSM_CMD_IO_BIT      = 0;
  localparam int CSM_CMD_MEM_BIT     = 1;
  localparam int CSM_DST_ERR_LSB     = 0;
  localparam int CSM_DST_ERR_W       = 4;
  localparam int CSM_DST_AUX_BIT     = 4;
  localparam int CSM_DST_PEND_BIT    = 5;
  localparam int CSM_LST_SPEED_LSB   = 0;
  localparam int CSM_LST_WIDTH_LSB   = 4;
  localparam int CSM_LST_TRAIN_BIT   = 11;
  localparam int CSM_LST_SLOTCLK_BIT = 12;
  localparam int CSM_LST_DLACT_BIT   = 13;
  localparam int CSM_LST_BWMGT_BIT   = 14;
  localparam int CSM_LST_AUTBW_BIT   = 15;

  localparam logic [7:0]  CSM_BUS_RST   = 8'h00;
  localparam logic [4:0]  CSM_DEV_RST   = 5'h00;
  localparam logic [2:0]  CSM_FUNC_NUM  = 3'h0;
  localparam logic [15:0] CSM_REG_RST   = 16'h0000;
  localparam logic [15:0] CSM_STATUS_NA = 16'h0000;

endpackage

// ==== rtl/csm_evt_if.sv ====
// Purpose: Carries device status events between the top and the status keeper.
// Assumes: All signals are in the user clock domain.
// Notes:   The top drives events and clears, the keeper returns the flags.
interface csm_evt_if;
  logic       ce;
  logic [3:0] err_set;
  logic [3:0] err_clr;
  logic       pending;
  logic [5:0] flags;

  modport keeper (
    input  ce,
    input  err_set,
    input  err_clr,
    input  pending,
    output flags
  );

  modport top (
    output ce,
    output err_set,
    output err_clr,
    output pending,
    input  flags
  );
endinterface

// ==== rtl/csm_dstat.sv ====
// Purpose: Keeps the sticky error flags of the device status mirror.
// Assumes: Clears are write-one-to-clear from configuration writes.
// Notes:   A set in the same cycle as its clear keeps the flag set.
module csm_dstat (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  csm_evt_if.keeper  evt
);

  logic [3:0] err_r;
  logic [3:0] err_nxt;
  logic       pend_r;

  // --------------------------------------------------------------------
  // Sticky error flags
  // --------------------------------------------------------------------
  assign err_nxt = (err_r & ~evt.err_clr) | evt.err_set;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      err_r  <= 4'h0;
      pend_r <= 1'b0;
    end else if (evt.ce) begin
      err_r  <= err_nxt;
      pend_r <= evt.pending;
    end
  end

  assign evt.flags = {pend_r, 1'b0, err_r};

endmodule

// ==== rtl/csm_top.sv ====
// Purpose: Mirrors configuration space registers onto parallel user buses.
// Assumes: All inputs come from core logic on i_clk; no synchronisers needed.
// Notes:   Writes arrive on one port; link-side Type 0 writes also carry the ID.
module csm_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire logic                  i_root_port,
  input  wire logic                  i_wr_valid,
  input  wire logic                  i_wr_type0,
  input  wire csm_pkg::csm_sel_e     i_wr_sel,
  input  wire logic [15:0]           i_wr_data,
  input  wire logic [7:0]            i_wr_bus,
  input  wire logic [4:0]            i_wr_dev,
  input  wire logic [3:0]            i_err_set,
  input  wire logic                  i_txn_pending,
  input  wire logic                  i_autbw_evt,
  input  wire logic                  i_bwmgt_evt,
  input  wire logic                  i_dl_active,
  input  wire logic                  i_slot_clk,
  input  wire logic                  i_link_training,
  input  wire logic [5:0]            i_link_width,
  input  wire logic [3:0]            i_link_speed,
  input  wire logic                  i_mem_req,
  input  wire logic                  i_io_req,
  output logic      [7:0]            o_bus_num,
  output logic      [4:0]            o_dev_num,
  output logic      [2:0]            o_func_num,
  output logic      [15:0]           o_status,
  output logic      [15:0]           o_command,
  output logic      [15:0]           o_dev_status,
  output logic      [15:0]           o_dev_ctl,
  output logic      [15:0]           o_link_status,
  output logic      [15:0]           o_link_ctl,
  output logic      [15:0]           o_dev_ctl2_mirror,
  output logic                       o_mem_accept,
  output logic                       o_io_accept
);

  // --------------------------------------------------------------------
  // Mode capture
  // --------------------------------------------------------------------
  logic        root_r;
  logic        mode_done_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      root_r      <= 1'b0;
      mode_done_r <= 1'b0;
    end else if (i_ce && !mode_done_r) begin
      root_r      <= i_root_port;
      mode_done_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  logic        wr_cmd;
  logic        wr_dst;
  logic        wr_dctl;
  logic        wr_lst;
  logic        wr_lctl;
  logic        wr_dctl2;
  logic        id_capture;
  logic [15:0] lctl_mask;

  assign wr_cmd     = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_COMMAND);
  assign wr_dst     = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_DEV_STATUS);
  assign wr_dctl    = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_DEV_CTL);
  assign wr_lst     = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_LINK_STATUS);
  assign wr_lctl    = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_LINK_CTL);
  assign wr_dctl2   = i_wr_valid && (i_wr_sel == csm_pkg::CSM_SEL_DEV_CTL2);
  assign id_capture = i_wr_valid && i_wr_type0;
  assign lctl_mask  = root_r ? csm_pkg::CSM_LCTL_WMASK
                             : csm_pkg::CSM_LCTL_EP_WMASK;

  // --------------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------------
  logic [15:0] cmd_nxt;
  logic [15:0] dctl_nxt;
  logic [15:0] lctl_nxt;
  logic [15:0] dctl2_nxt;
  logic [15:0] lst_nxt;
  logic [1:0]  lst_w1c;
  logic [1:0]  lst_sticky;
  logic [1:0]  lst_evt;
  logic [7:0]  bus_nxt;
  logic [4:0]  dev_nxt;

  assign cmd_nxt   = wr_cmd ? (i_wr_data & csm_pkg::CSM_CMD_WMASK)
                            : o_command;
  assign dctl_nxt  = wr_dctl ? (i_wr_data & csm_pkg::CSM_DCTL_WMASK)
                             : o_dev_ctl;
  assign lctl_nxt  = wr_lctl ? (i_wr_data & lctl_mask)
                             : (o_link_ctl & lctl_mask);
  assign dctl2_nxt = wr_dctl2 ? (i_wr_data & csm_pkg::CSM_DCTL2_WMASK)
                              : o_dev_ctl2_mirror;
  assign bus_nxt   = id_capture ? i_wr_bus : o_bus_num;
  assign dev_nxt   = id_capture ? i_wr_dev : o_dev_num;

  // Bandwidth status flags are sticky; a new event wins over a clear.
  assign lst_w1c    = wr_lst ? i_wr_data[15:14] : 2'b00;
  assign lst_evt    = {i_autbw_evt, i_bwmgt_evt};

  for (genvar b = 0; b < 2; b++) begin : g_bw_sticky
    assign lst_sticky[b] = (o_link_status[csm_pkg::CSM_LST_BWMGT_BIT + b] & ~lst_w1c[b])
                         | lst_evt[b];
  end
  assign lst_nxt    = {lst_sticky,
                       i_dl_active,
                       i_slot_clk,
                       i_link_training,
                       1'b0,
                       i_link_width,
                       i_link_speed};

  // --------------------------------------------------------------------
  // Device status keeper
  // --------------------------------------------------------------------
  csm_evt_if evt_bus ();

  assign evt_bus.ce      = i_ce;
  assign evt_bus.err_set = i_err_set;
  assign evt_bus.err_clr = wr_dst ? i_wr_data[3:0] : 4'h0;
  assign evt_bus.pending = i_txn_pending;

  csm_dstat u_dstat (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .evt     (evt_bus.keeper)
  );

  assign o_dev_status = {10'h000, evt_bus.flags};

  // --------------------------------------------------------------------
  // Request acceptance
  // --------------------------------------------------------------------
  logic mem_ok;
  logic io_ok;

  assign mem_ok = i_mem_req && o_command[csm_pkg::CSM_CMD_MEM_BIT];
  assign io_ok  = i_io_req && o_command[csm_pkg::CSM_CMD_IO_BIT];

  // --------------------------------------------------------------------
  // Captured identifier
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bus_num  <= csm_pkg::CSM_BUS_RST;
      o_dev_num  <= csm_pkg::CSM_DEV_RST;
      o_func_num <= csm_pkg::CSM_FUNC_NUM;
    end else if (i_ce) begin
      o_bus_num  <= bus_nxt;
      o_dev_num  <= dev_nxt;
      o_func_num <= csm_pkg::CSM_FUNC_NUM;
    end
  end

  // --------------------------------------------------------------------
  // Status mirror
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status <= csm_pkg::CSM_STATUS_NA;
    end else if (i_ce) begin
      o_status <= csm_pkg::CSM_STATUS_NA;
    end
  end

  // --------------------------------------------------------------------
  // Command mirror
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_command <= csm_pkg::CSM_REG_RST;
    end else if (i_ce) begin
      o_command <= cmd_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Device control mirrors
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dev_ctl         <= csm_pkg::CSM_REG_RST;
      o_dev_ctl2_mirror <= csm_pkg::CSM_REG_RST;
    end else if (i_ce) begin
      o_dev_ctl         <= dctl_nxt;
      o_dev_ctl2_mirror <= dctl2_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Link control mirror
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_link_ctl <= csm_pkg::CSM_REG_RST;
    end else if (i_ce) begin
      o_link_ctl <= lctl_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Link status mirror
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_link_status <= csm_pkg::CSM_REG_RST;
    end else if (i_ce) begin
      o_link_status <= lst_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Accept pulses
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_mem_accept <= 1'b0;
      o_io_accept  <= 1'b0;
    end else if (i_ce) begin
      o_mem_accept <= mem_ok;
      o_io_accept  <= io_ok;
    end
  end

endmodule

// ==== sim/csm_assertions.sv ====
// Purpose: Concurrent checks on the mirror outputs of csm_top.
// Assumes: Single clock i_clk, synchronous active-low reset.
// Notes:   Attached by the bind after the module.
module csm_assertions (
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_ce,
  input wire logic               i_wr_valid,
  input wire logic               i_wr_type0,
  input wire csm_pkg::csm_sel_e  i_wr_sel,
  input wire logic [15:0]        i_wr_data,
  input wire logic [7:0]         i_wr_bus,
  input wire logic [4:0]         i_wr_dev,
  input wire logic               i_mem_req,
  input wire logic               i_io_req,
  input wire logic [7:0]         o_bus_num,
  input wire logic [4:0]         o_dev_num,
  input wire logic [2:0]         o_func_num,
  input wire logic [15:0]        o_status,
  input wire logic [15:0]        o_command,
  input wire logic [15:0]        o_dev_status,
  input wire logic [15:0]        o_dev_ctl,
  input wire logic [15:0]        o_link_status,
  input wire logic [15:0]        o_link_ctl,
  input wire logic [15:0]        o_dev_ctl2_mirror,
  input wire logic               o_mem_accept,
  input wire logic               o_io_accept
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_id_wr;
    i_ce && i_wr_valid && i_wr_type0;
  endsequence
  sequence s_cmd_wr;
    i_ce && i_wr_valid && i_wr_sel == csm_pkg::CSM_SEL_COMMAND;
  endsequence
  a_fixed_zero: assert property (o_func_num == 3'h0 && o_status == 16'h0000)
    else $error("function number or status mirror not zero");
  a_cmd_resv: assert property ((o_command & 16'hfaf8) == 16'h0000)
    else $error("reserved command bit set");
  a_cmd_write: assert property (s_cmd_wr |=> o_command == ($past(i_wr_data) & 16'h0507))
    else $error("command mirror not updated");
  a_dstat_resv: assert property (o_dev_status[15:6] == 10'h000 && !o_dev_status[4])
    else $error("reserved device status bit set");
  a_dctl_resv: assert property (!o_dev_ctl[15] && !o_link_status[10])
    else $error("reserved control or link status bit set");
  a_lctl_resv: assert property (o_link_ctl[15:12] == 4'h0 && !o_link_ctl[2])
    else $error("reserved link control bit set");
  a_dctl2_resv: assert property (o_dev_ctl2_mirror[15:5] == 11'h000)
    else $error("reserved device control 2 bit set");
  a_id_capture: assert property (s_id_wr |=> {o_bus_num, o_dev_num} ==
    {$past(i_wr_bus), $past(i_wr_dev)}) else $error("identifier not captured");
  a_id_hold: assert property (!(i_ce && i_wr_valid && i_wr_type0) |=>
    $stable(o_bus_num) && $stable(o_dev_num)) else $error("identifier changed");
  a_mem_gate: assert property (i_ce && i_mem_req |=> o_mem_accept == $past(o_command[1]))
    else $error("memory accept wrong");
  a_io_gate: assert property (i_ce && i_io_req |=> o_io_accept == $past(o_command[0]))
    else $error("io accept wrong");
endmodule
bind csm_top csm_assertions csm_assertions_i (.i_clk, .i_rst_n, .i_ce, .i_wr_valid,
  .i_wr_type0, .i_wr_sel, .i_wr_data, .i_wr_bus, .i_wr_dev, .i_mem_req, .i_io_req,
  .o_bus_num, .o_dev_num, .o_func_num, .o_status, .o_command, .o_dev_status, .o_dev_ctl,
  .o_link_status, .o_link_ctl, .o_dev_ctl2_mirror, .o_mem_accept, .o_io_accept);

// ==== sim/csm_user_model.sv ====
// Purpose: User logic that originates requests using the mirrors.
// Assumes: Runs on the user clock.
// Notes:   Requests are held off while bus master enable is clear.
module csm_user_model (
  input  wire logic        i_clk,
  input  wire logic        i_want,
  input  wire logic [15:0] i_command,
  input  wire logic [15:0] i_core_id,
  output logic             o_req,
  output logic [15:0]      o_req_id
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_clk) begin
    o_req    <= i_want && i_command[2];
    o_req_id <= i_core_id;
  end
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for csm_top.
// Assumes: Endpoint mode, then root port mode after a second reset; inputs move 5 ns after an edge.
// Notes:   Each write task ends with an idle cycle, so two calls never merge into one strobe.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, ce = 1, wv = 0, t0 = 0, mreq = 0, ireq = 0, pend = 0;
  logic ab = 0, bm = 0, dla = 0, sck = 0, trn = 0, want = 0, rp = 0, ma, ia, ureq;
  csm_pkg::csm_sel_e sel = csm_pkg::CSM_SEL_COMMAND;
  logic [15:0] wd = 0, st, cmd, ds, dc, ls, lc, d2, uid;
  logic [7:0]  bus = 0, bn;
  logic [4:0]  dev = 0, dn;
  logic [3:0]  es = 0, spd = 0;
  logic [5:0]  wid = 0;
  logic [2:0]  fn;
  int err_count = 0, checked = 0, cycles = 0;
  csm_top csm_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_root_port(rp),
    .i_wr_valid(wv), .i_wr_type0(t0), .i_wr_sel(sel), .i_wr_data(wd), .i_wr_bus(bus),
    .i_wr_dev(dev), .i_err_set(es), .i_txn_pending(pend), .i_autbw_evt(ab),
    .i_bwmgt_evt(bm), .i_dl_active(dla), .i_slot_clk(sck), .i_link_training(trn),
    .i_link_width(wid), .i_link_speed(spd), .i_mem_req(mreq), .i_io_req(ireq),
    .o_bus_num(bn), .o_dev_num(dn), .o_func_num(fn), .o_status(st), .o_command(cmd),
    .o_dev_status(ds), .o_dev_ctl(dc), .o_link_status(ls), .o_link_ctl(lc),
    .o_dev_ctl2_mirror(d2), .o_mem_accept(ma), .o_io_accept(ia));
  csm_user_model csm_user_model_i (.i_clk(clk), .i_want(want), .i_command(cmd),
    .i_core_id({bn, dn, fn}), .o_req(ureq), .o_req_id(uid));
  initial forever #25 clk = ~clk;
  task cyc;
    @(posedge clk);
    #5;
  endtask
  task summarize;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input csm_pkg::csm_sel_e s, input logic [15:0] d);
    sel = s;
    wd = d;
    wv = 1;
    cyc;
    wv = 0;
    cyc;
  endtask
  task req(input logic m, input logic i);
    mreq = m;
    ireq = i;
    cyc;
    mreq = 0;
    ireq = 0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    repeat (6) cyc;
    rst_n = 1;
    cyc;
    chk({bn, dn, fn}, 16'h0000);
    chk(st, 16'h0000);
    wr(csm_pkg::CSM_SEL_COMMAND, 16'hffff);
    chk(cmd, 16'h0507);
    wr(csm_pkg::CSM_SEL_DEV_CTL, 16'hffff);
    chk(dc, 16'h7fff);
    wr(csm_pkg::CSM_SEL_LINK_CTL, 16'hffff);
    chk(lc, 16'h0fdb);
    wr(csm_pkg::CSM_SEL_DEV_CTL2, 16'hffff);
    chk(d2, 16'h001f);
    bus = 8'ha5;
    dev = 5'h13;
    t0 = 1;
    wr(csm_pkg::CSM_SEL_DEV_CTL, 16'h0000);
    t0 = 0;
    bus = 8'h00;
    dev = 5'h00;
    chk({bn, dn, fn}, 16'ha598);
    chk(dc, 16'h0000);
    wr(csm_pkg::CSM_SEL_COMMAND, 16'h0404);
    chk({bn, dn, fn}, 16'ha598);
    req(1, 1);
    chk({14'h0, ma, ia}, 16'h0000);
    wr(csm_pkg::CSM_SEL_COMMAND, 16'h0001);
    req(1, 1);
    chk({14'h0, ma, ia}, 16'h0001);
    wr(csm_pkg::CSM_SEL_COMMAND, 16'h0003);
    req(1, 1);
    chk({14'h0, ma, ia}, 16'h0003);
    cyc;
    chk({14'h0, ma, ia}, 16'h0000);
    want = 1;
    cyc;
    chk({15'h0, ureq}, 16'h0000);
    wr(csm_pkg::CSM_SEL_COMMAND, 16'h0004);
    chk({15'h0, ureq}, 16'h0001);
    chk(uid, 16'ha598);
    want = 0;
    es = 4'h5;
    pend = 1;
    cyc;
    chk(ds, 16'h0025);
    es = 4'h4;
    wr(csm_pkg::CSM_SEL_DEV_STATUS, 16'h0005);
    es = 4'h0;
    chk(ds, 16'h0024);
    pend = 0;
    wr(csm_pkg::CSM_SEL_DEV_STATUS, 16'h0004);
    chk(ds, 16'h0000);
    wid = 6'h08;
    spd = 4'h2;
    dla = 1;
    sck = 1;
    trn = 1;
    ab = 1;
    bm = 1;
    cyc;
    ab = 0;
    bm = 0;
    chk(ls, 16'hf882);
    cyc;
    chk(ls, 16'hf882);
    wr(csm_pkg::CSM_SEL_LINK_STATUS, 16'hc000);
    chk(ls, 16'h3882);
    ce = 0;
    wr(csm_pkg::CSM_SEL_DEV_CTL2, 16'h0000);
    ce = 1;
    chk(d2, 16'h001f);
    rst_n = 0;
    rp = 1;
    repeat (2) cyc;
    rst_n = 1;
    cyc;
    chk({bn, dn, fn}, 16'h0000);
    chk(cmd, 16'h0000);
    wr(csm_pkg::CSM_SEL_LINK_CTL, 16'hffff);
    chk(lc, 16'h0ffb);
    summarize;
  end
endmodule
